/* File: hw/hpc_pkg.sv */
// Purpose: shared constants for the hub port power and strap control block
// Assumes: 40 MHz system clock
// Notes:   all counts are in clk cycles
package hpc_pkg;
  localparam int          NUM_PORTS        = 4;
  // straps are held off for a settle time after reset release
  localparam int          STRAP_SETTLE_NS  = 1000;
  localparam int          CLK_PERIOD_NS    = 25;
  localparam int          STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SETTLE_CNT_RST   = 8'h00;
  // power pins read back off (high) until the straps are latched
  localparam logic        POWER_OFF_LEVEL  = 1'b1;
  localparam logic        POWER_ON_LEVEL   = 1'b0;
  localparam logic        FIXED_RST_ACTIVE = 1'b0;
  localparam logic        ROM_SELECT_IDLE  = 1'b1;
endpackage

/* File: hw/hpc_sync2.sv */
// Purpose: two-flop synchroniser, one per bit
// Assumes: asynchronous pin inputs
// Notes:   first stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module hpc_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             clkEn,
  // data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] stage2_next;

  always_comb
  begin
    stage1_next = clkEn ? asyncIn : stage1_reg;
    stage2_next = clkEn ? stage1_reg : stage2_reg;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      stage1_reg <= '1;
      stage2_reg <= '1;
    end
    else
    begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign syncOut = stage2_reg;
endmodule
`default_nettype wire

/* File: hw/hpc_port_ctrl.sv */
// Summary of operation
// - low on a port overcurrent input means overcurrent, high means none
// - overcurrent strap high: removable port with overcurrent; low: non-removable
// - port1 power strap high: power control; low: fixed device reset output
// - power outputs drive low for VBUS on, high for off
// - port2 power strap high selects individual control, low selects ganged
// - drive active-low ROM select, and sample it as ROM-use strap
// - serial clock pin is ROM clock or port4 indicator by strap
// - ROM mode: serial input takes ROM data; else port3 indicator
// - ROM mode: serial output sends ROM data; else port2 indicator
// - ROM select strapped high means external ROM present and used
// - indicator driven low while port enabled, released while disabled
//
// Purpose: downstream port power, overcurrent and strap control of a hub
// Assumes: dual-use pins are weakly strapped and read while released
// Notes:   output enables are low while the pin is driven
`timescale 1ns/100ps
`default_nettype none
module hpc_port_ctrl #(
  parameter int NPORTS = hpc_pkg::NUM_PORTS
) (
  // clock, enable, reset
  input  wire logic              clk,
  input  wire logic              clkEn,
  input  wire logic              nrst,
  // overcurrent pins
  input  wire logic [NPORTS-1:0] overcurrentN,
  // power pins (two-way, strapped)
  input  wire logic [NPORTS-1:0] powerOnNIn,
  output logic      [NPORTS-1:0] powerOnNOut,
  output logic      [NPORTS-1:0] powerOnNOeN,
  // rom pins (two-way, strapped)
  input  wire logic              romSelectNIn,
  output logic                   romSelectNOut,
  output logic                   romSelectNOeN,
  input  wire logic              romClockIn,
  output logic                   romClockOut,
  output logic                   romClockOeN,
  input  wire logic              romDataFromRomIn,
  output logic                   romDataFromRomOut,
  output logic                   romDataFromRomOeN,
  input  wire logic              romDataToRomIn,
  output logic                   romDataToRomOut,
  output logic                   romDataToRomOeN,
  // hub core side
  input  wire logic [NPORTS-1:0] portPowerReq,
  input  wire logic [NPORTS-1:0] portEnabled,
  input  wire logic              fixedDeviceResetReq,
  input  wire logic              romSelectReq,
  input  wire logic              romClockReq,
  input  wire logic              romDataToRomReq,
  output logic                   romDataFromRom,
  // status
  output logic [NPORTS-1:0]      portOvercurrent,
  output logic [NPORTS-1:0]      portRemovable,
  output logic                   individualPower,
  output logic                   port1PowerCtrl,
  output logic                   romUsed,
  output logic                   strapsValid
);
  logic                  rstSync1_reg;
  logic                  rstSync2_reg;
  logic                  rstN;
  logic [NPORTS-1:0]     ocSync;
  logic [NPORTS-1:0]     pwrSync;
  logic [3:0]            romSync;
  logic [7:0]            settle_reg;
  logic [7:0]            settle_next;
  logic                  valid_reg;
  logic                  valid_next;
  logic [NPORTS-1:0]     removable_reg;
  logic [NPORTS-1:0]     removable_next;
  logic                  indiv_reg;
  logic                  indiv_next;
  logic                  p1ctrl_reg;
  logic                  p1ctrl_next;
  logic                  rom_reg;
  logic                  rom_next;
  logic [NPORTS-1:0]     oc_reg;
  logic [NPORTS-1:0]     oc_next;
  logic [NPORTS-1:0]     pwr_reg;
  logic [NPORTS-1:0]     pwr_next;
  logic [3:0]            romOut_reg;
  logic [3:0]            romOut_next;
  logic [3:0]            romOe_reg;
  logic [3:0]            romOe_next;
  logic                  romIn_reg;
  logic                  romIn_next;
  logic                  gangReq;

  // reset release through two flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end
    else
    begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end
  assign rstN = rstSync2_reg;

  hpc_sync2 #(.WIDTH(2*NPORTS+4)) uSync (
    .clk     (clk),
    .rstN    (rstN),
    .clkEn   (clkEn),
    .asyncIn ({overcurrentN, powerOnNIn, romSelectNIn, romClockIn,
               romDataFromRomIn, romDataToRomIn}),
    .syncOut ({ocSync, pwrSync, romSync})
  );

  assign gangReq = |portPowerReq;

  always_comb
  begin
    settle_next    = settle_reg;
    valid_next     = valid_reg;
    removable_next = removable_reg;
    indiv_next     = indiv_reg;
    p1ctrl_next    = p1ctrl_reg;
    rom_next       = rom_reg;
    if (!valid_reg)
    begin
      if (settle_reg == 8'(hpc_pkg::STRAP_SETTLE_CYC))
      begin
        valid_next     = 1'b1;
        removable_next = ocSync;
        indiv_next     = pwrSync[1];
        p1ctrl_next    = pwrSync[0];
        rom_next       = romSync[3];
      end
      else
        settle_next = settle_reg + 8'h01;
    end
  end

  always_comb
  begin
    // low means overcurrent, only on removable ports
    oc_next = ~ocSync & removable_reg & {NPORTS{valid_reg}};
    pwr_next = {NPORTS{hpc_pkg::POWER_OFF_LEVEL}};
    if (valid_reg)
    begin
      for (int i = 0; i < NPORTS; i++)
        pwr_next[i] = (indiv_reg ? portPowerReq[i] : gangReq) ?
                      hpc_pkg::POWER_ON_LEVEL : hpc_pkg::POWER_OFF_LEVEL;
      if (!p1ctrl_reg)
        pwr_next[0] = fixedDeviceResetReq ? hpc_pkg::FIXED_RST_ACTIVE : ~hpc_pkg::FIXED_RST_ACTIVE;
    end
    // bit3 select, bit2 clock, bit1 data from rom, bit0 data to rom
    romOut_next = {hpc_pkg::ROM_SELECT_IDLE, 3'h0};
    romOe_next  = 4'hF;
    romIn_next  = romIn_reg;
    if (valid_reg)
    begin
      if (rom_reg)
      begin
        romOut_next = {~romSelectReq, romClockReq, 1'b0, romDataToRomReq};
        romOe_next  = 4'h2;
        romIn_next  = romSync[1];
      end
      else
      begin
        // low when enabled, released otherwise; indicator roles
        romOut_next = {hpc_pkg::ROM_SELECT_IDLE, 3'h0};
        romOe_next  = {1'b0, ~portEnabled[3], ~portEnabled[2], ~portEnabled[1]};
      end
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      settle_reg    <= hpc_pkg::SETTLE_CNT_RST;
      valid_reg     <= 1'b0;
      removable_reg <= '1;
      indiv_reg     <= 1'b1;
      p1ctrl_reg    <= 1'b1;
      rom_reg       <= 1'b0;
      oc_reg        <= '0;
      pwr_reg       <= '1;
      romOut_reg    <= 4'h8;
      romOe_reg     <= 4'hF;
      romIn_reg     <= 1'b0;
    end
    else if (clkEn)
    begin
      settle_reg    <= settle_next;
      valid_reg     <= valid_next;
      removable_reg <= removable_next;
      indiv_reg     <= indiv_next;
      p1ctrl_reg    <= p1ctrl_next;
      rom_reg       <= rom_next;
      oc_reg        <= oc_next;
      pwr_reg       <= pwr_next;
      romOut_reg    <= romOut_next;
      romOe_reg     <= romOe_next;
      romIn_reg     <= romIn_next;
    end
  end

  // power pins released until straps latched so the strap is readable
  assign powerOnNOut       = pwr_reg;
  assign powerOnNOeN       = {NPORTS{~valid_reg}};
  assign romSelectNOut     = romOut_reg[3];
  assign romSelectNOeN     = romOe_reg[3];
  assign romClockOut       = romOut_reg[2];
  assign romClockOeN       = romOe_reg[2];
  assign romDataFromRomOut = romOut_reg[1];
  assign romDataFromRomOeN = romOe_reg[1];
  assign romDataToRomOut   = romOut_reg[0];
  assign romDataToRomOeN   = romOe_reg[0];
  assign romDataFromRom    = romIn_reg;
  assign portOvercurrent   = oc_reg;
  assign portRemovable     = removable_reg;
  assign individualPower   = indiv_reg;
  assign port1PowerCtrl    = p1ctrl_reg;
  assign romUsed           = rom_reg;
  assign strapsValid       = valid_reg;

  property p_oc;
    @(posedge clk) disable iff (!rstN)
    (clkEn && valid_reg && removable_reg[1] && !ocSync[1]) |=> portOvercurrent[1];
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent not flagged");

  property p_nonrem;
    @(posedge clk) disable iff (!rstN)
    (valid_reg && !removable_reg[2]) |=> !portOvercurrent[2];
  endproperty
  a_nonrem: assert property (p_nonrem) else $error("nonremovable flagged");

  property p_p1rst;
    @(posedge clk) disable iff (!rstN)
    (clkEn && valid_reg && !p1ctrl_reg && fixedDeviceResetReq) |=> !powerOnNOut[0];
  endproperty
  a_p1rst: assert property (p_p1rst) else $error("fixed reset not driven");

  property p_pwr;
    @(posedge clk) disable iff (!rstN)
    (clkEn && valid_reg && indiv_reg && portPowerReq[3]) |=> !powerOnNOut[3] && !powerOnNOeN[3];
  endproperty
  a_pwr: assert property (p_pwr) else $error("power not on");

  property p_gang;
    @(posedge clk) disable iff (!rstN)
    (clkEn && valid_reg && !indiv_reg && gangReq) |=> !powerOnNOut[2];
  endproperty
  a_gang: assert property (p_gang) else $error("gang power off");

  property p_sel;
    @(posedge clk) disable iff (!rstN)
    (clkEn && valid_reg && rom_reg && romSelectReq) |=> !romSelectNOut && !romSelectNOeN;
  endproperty
  a_sel: assert property (p_sel) else $error("rom select wrong");

  property p_led;
    @(posedge clk) disable iff (!rstN)
    (clkEn && valid_reg && !rom_reg && !portEnabled[3]) |=> romClockOeN;
  endproperty
  a_led: assert property (p_led) else $error("indicator driven");

  property p_hold;
    @(posedge clk) disable iff (!rstN)
    strapsValid |=> $stable(romUsed) && $stable(individualPower) && strapsValid;
  endproperty
  a_hold: assert property (p_hold) else $error("strap changed");
endmodule
`default_nettype wire

/* File: tb/hpc_far_side.sv */
// Purpose: straps, pull-ups and serial rom beyond the pins
// Assumes: straps are weak, a driving pin wins
// Notes:   rom pins indexed cs, clock, from rom, to rom
`timescale 1ns/100ps
`default_nettype none
module hpc_far_side (
  // straps and rom data
  input  wire logic [3:0] ppStrap,
  input  wire logic       csStrap,
  input  wire logic       romBit,
  // pin drives
  input  wire logic [3:0] ppOut,
  input  wire logic [3:0] ppOeN,
  input  wire logic [3:0] romOut,
  input  wire logic [3:0] romOeN,
  // resolved levels
  output logic      [3:0] ppIn,
  output logic      [3:0] romIn
);
  logic romDrive;
  assign ppIn = (ppOeN & ppStrap) | (~ppOeN & ppOut);
  assign romIn[0] = romOeN[0] ? csStrap : romOut[0];
  assign romIn[1] = romOeN[1] | romOut[1];
  // rom takes this level as its data in
  assign romIn[3] = romOeN[3] | romOut[3];
  assign romDrive = romOeN[2] & ~romIn[0];
  assign romIn[2] = romDrive ? romBit : (romOeN[2] | romOut[2]);
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: self-checking bench for port power and strap control
// Assumes: clkEn dropped at random to check freezing, stimulus on falling edges
// Notes:   inputs held 4 cycles so every latency has settled
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [3:0] ocN = 4'hF, ppStrap = 4'hF, ppReq = 4'h0, portEn = 4'h0;
  logic       csStrap = 1'b0, romBit = 1'b0, fixRst = 1'b1;
  logic       selReq = 1'b0, sckReq = 1'b0, siReq = 1'b0;
  logic       clkEn = 1'b1;
  logic [3:0] remE;
  wire  [3:0] ppIn, ppOut, ppOeN, romIn, romOut, romOeN, ovc, remov;
  wire        romData, indiv, p1Ctrl, romUsed, valid;
  int         nErrors = 0;
  int         samplesChecked = 0;
  logic [31:0] seed = 32'h4A27;
  always #12.5 clk = ~clk;
  hpc_port_ctrl i_dut (.clk(clk), .clkEn(clkEn), .nrst(nrst), .overcurrentN(ocN),
    .powerOnNIn(ppIn), .powerOnNOut(ppOut), .powerOnNOeN(ppOeN),
    .romSelectNIn(romIn[0]), .romSelectNOut(romOut[0]), .romSelectNOeN(romOeN[0]),
    .romClockIn(romIn[1]), .romClockOut(romOut[1]), .romClockOeN(romOeN[1]),
    .romDataFromRomIn(romIn[2]), .romDataFromRomOut(romOut[2]),
    .romDataFromRomOeN(romOeN[2]), .romDataToRomIn(romIn[3]),
    .romDataToRomOut(romOut[3]), .romDataToRomOeN(romOeN[3]),
    .portPowerReq(ppReq), .portEnabled(portEn), .fixedDeviceResetReq(fixRst),
    .romSelectReq(selReq), .romClockReq(sckReq), .romDataToRomReq(siReq),
    .romDataFromRom(romData), .portOvercurrent(ovc), .portRemovable(remov),
    .individualPower(indiv), .port1PowerCtrl(p1Ctrl), .romUsed(romUsed),
    .strapsValid(valid));
  hpc_far_side i_far (.ppStrap(ppStrap), .csStrap(csStrap), .romBit(romBit),
    .ppOut(ppOut), .ppOeN(ppOeN), .romOut(romOut), .romOeN(romOeN),
    .ppIn(ppIn), .romIn(romIn));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      nErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one random setting of the core levels, then the expected pins
  task automatic step();
    logic [31:0] r;
    logic [3:0]  pw;
    logic [7:0]  pinSnap;
    logic [7:0]  romSnap;
    r = rnd();
    pinSnap = {ppOut, ovc};
    romSnap = {romOut, romOeN};
    {ppReq, portEn, ocN, fixRst, selReq, sckReq, siReq, romBit} = r[16:0];
    // a low enable must hold every output while the pins move
    if (r[17])
    begin
      clkEn = 1'b0;
      repeat (2) @(negedge clk);
      chk({ppOut, ovc}, pinSnap);
      chk({romOut, romOeN}, romSnap);
      clkEn = 1'b1;
    end
    repeat (4) @(negedge clk);
    pw = ppStrap[1] ? ~ppReq : {4{~|ppReq}};
    if (!ppStrap[0])
      pw[0] = ~fixRst;
    chk(ppOut, pw);
    chk(ppOeN, 8'h00);
    chk(ovc, ~ocN & remE);
    if (csStrap)
    begin
      chk({romOut[0], romOut[1], romOut[3], romOeN[2]}, {~selReq, sckReq, siReq, 1'b1});
      chk({romOeN[0], romOeN[1], romOeN[3]}, 8'h00);
      if (selReq)
        chk(romData, romBit);
    end
    else
    begin
      chk({romOut[0], romOeN[0]}, 8'h02);
      chk({romIn[1], romIn[2], romIn[3]}, {~portEn[3:1]});
    end
  endtask
  // reset with a strap set, then random traffic
  task automatic strap_run(input logic [2:0] mode);
    int w;
    nrst = 1'b0;
    remE = 4'(rnd());
    ocN = remE;
    ppStrap = {2'(rnd() >> 7), mode[1:0]};
    csStrap = mode[2];
    repeat (5) @(negedge clk);
    chk({ppOeN, romOeN}, 8'hFF);
    chk({ppOut, romOut[0], valid, romUsed}, 8'h7C);
    nrst = 1'b1;
    for (w = 0; w < 80 && valid !== 1'b1; w++)
      @(negedge clk);
    chk(valid, 8'h01);
    chk(remov, remE);
    chk(indiv, ppStrap[1]);
    chk(p1Ctrl, ppStrap[0]);
    chk(romUsed, csStrap);
    repeat (20) step();
  endtask
  initial
  begin
    for (int i = 0; i < 8; i++)
      strap_run(i[2:0]);
    summarize();
  end
  // run needs about 1200 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    nErrors++;
    summarize();
  end
endmodule
`default_nettype wire
